// [rx_port_status_regs.sv]
// receive-port status flags and paged write gating for a two-port link receiver
//
// Notes on behaviour
// R1: page-select bit 0 lets host writes reach port 0 paged registers only when set.
// R2: page-select bit 1 lets host writes reach port 1 paged registers only when set.
// R3: with both enables set one paged write updates both ports together.
// R4: control-channel access defaults its own port enable to 1, local access defaults both to 0.
// R5: status one bit 6 reports the port currently selected for readback.
// R6: status one bit 5 latches a control-channel crc error and clears on read.
// R7: status one bit 3 latches a control-channel sequence error and clears on read.
// R8: status one bit 2 latches when the parity count exceeds the programmed limit.
// R9: the parity flag clears only together with the parity count, not on a status read.
// R10: status one bit 1 shows live whether the input meets the pass criteria.
// R11: status one bit 0 shows live whether the receiver is locked.
// R12: status two bit 5 latches a line-encoding error and clears on read.
// R13: a read-port field picks the port returned on reads, default 0 locally, own port remotely.
// R14: the parity count clears on valid lock or a read of its low byte, clearing the flag too.
// R15: an error arriving in the cycle of a clearing read leaves the flag set.
`timescale 1ns/1ps
module rx_port_status_regs (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_src_bcc,
  input wire logic reg_src_port,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [1:0] crc_err_evt,
  input wire logic [1:0] seq_err_evt,
  input wire logic [1:0] parity_err_evt,
  input wire logic [1:0] encode_err_evt,
  input wire logic [1:0] receiver_locked,
  input wire logic [1:0] pass_ok
);

  function automatic logic latch_next(input logic flag, input logic set, input logic clr);
    latch_next = set | (flag & ~clr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // access source and page selection
  logic [7:0] sel_reg [rx_status_pkg::NUM_SRC];
  wire [1:0] src = reg_src_bcc ? (reg_src_port ? rx_status_pkg::SRC_BCC1
                                               : rx_status_pkg::SRC_BCC0)
                               : rx_status_pkg::SRC_LOCAL;
  wire [7:0] cur_sel = sel_reg[src];
  wire [1:0] wr_en = {cur_sel[rx_status_pkg::SEL_WE1_BIT], cur_sel[rx_status_pkg::SEL_WE0_BIT]};
  wire rp = cur_sel[rx_status_pkg::SEL_RD_BIT];
  wire [1:0] phys_port = reg_src_bcc ? {1'b0, reg_src_port} : 2'h0;

  wire wr_sel = reg_wr && (reg_addr == rx_status_pkg::ADDR_PAGE_SEL);
  wire wr_lim_hi = reg_wr && (reg_addr == rx_status_pkg::ADDR_PAR_LIM_HI);
  wire wr_lim_lo = reg_wr && (reg_addr == rx_status_pkg::ADDR_PAR_LIM_LO);
  wire rd_sts1 = reg_rd && (reg_addr == rx_status_pkg::ADDR_STS_ONE);
  wire rd_sts2 = reg_rd && (reg_addr == rx_status_pkg::ADDR_STS_TWO);
  wire rd_cnt_lo = reg_rd && (reg_addr == rx_status_pkg::ADDR_PAR_CNT_LO);
  wire [7:0] next_sel = (cur_sel & ~rx_status_pkg::SEL_WMASK)
                      | (reg_wdata & rx_status_pkg::SEL_WMASK);

  // each source keeps its own select copy so its defaults hold
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sel_reg[rx_status_pkg::SRC_LOCAL] <= rx_status_pkg::SEL_RST_LOCAL; // see R4 see R13
      sel_reg[rx_status_pkg::SRC_BCC0] <= rx_status_pkg::SEL_RST_BCC0; // see R4 see R13
      sel_reg[rx_status_pkg::SRC_BCC1] <= rx_status_pkg::SEL_RST_BCC1; // see R4 see R13
    end else if (wr_sel) begin
      sel_reg[src] <= next_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port status and parity logic
  logic [1:0] crc_flag;
  logic [1:0] seq_flag;
  logic [1:0] par_flag;
  logic [1:0] enc_flag;
  logic [1:0] lock_change_flag;
  logic [1:0] lock_prev;
  logic [15:0] par_cnt [rx_status_pkg::NUM_PORTS];
  logic [15:0] par_lim [rx_status_pkg::NUM_PORTS];
  wire [1:0] par_clr;
  wire [1:0] rd_here;
  wire [1:0] over_lim;

  genvar p;
  generate
    for (p = 0; p < rx_status_pkg::NUM_PORTS; p++) begin : g_port
      wire wr_here = wr_en[p]; // see R1 see R2 see R3
      wire lock_rise = receiver_locked[p] & ~lock_prev[p];
      assign rd_here[p] = (rp == 1'(p)); // see R13
      assign par_clr[p] = lock_rise | (rd_cnt_lo & rd_here[p]); // see R14
      assign over_lim[p] = par_cnt[p] > par_lim[p];
      wire [15:0] cnt_inc = (par_cnt[p] == rx_status_pkg::PAR_CNT_MAX) ? par_cnt[p]
                          : par_cnt[p] + rx_status_pkg::PAR_CNT_ONE;
      wire [15:0] next_cnt = par_clr[p] ? (parity_err_evt[p] ? rx_status_pkg::PAR_CNT_ONE
                                                             : rx_status_pkg::PAR_CNT_RST)
                           : (parity_err_evt[p] ? cnt_inc : par_cnt[p]);

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          crc_flag[p] <= 1'b0;
          seq_flag[p] <= 1'b0;
          enc_flag[p] <= 1'b0;
          lock_change_flag[p] <= 1'b0;
          lock_prev[p] <= 1'b0;
          par_flag[p] <= 1'b0;
          par_cnt[p] <= rx_status_pkg::PAR_CNT_RST;
        end else begin
          crc_flag[p] <= latch_next(crc_flag[p], crc_err_evt[p],
                                    rd_sts1 & rd_here[p]); // see R6 see R15
          seq_flag[p] <= latch_next(seq_flag[p], seq_err_evt[p],
                                    rd_sts1 & rd_here[p]); // see R7 see R15
          enc_flag[p] <= latch_next(enc_flag[p], encode_err_evt[p],
                                    rd_sts2 & rd_here[p]); // see R12 see R15
          lock_change_flag[p] <= latch_next(lock_change_flag[p],
                                            receiver_locked[p] ^ lock_prev[p],
                                            rd_sts1 & rd_here[p]);
          lock_prev[p] <= receiver_locked[p];
          par_flag[p] <= par_clr[p] ? 1'b0 : (par_flag[p] | over_lim[p]); // see R8 see R9 see R14
          par_cnt[p] <= next_cnt; // see R14
        end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          par_lim[p] <= rx_status_pkg::PAR_LIM_RST;
        end else if (wr_here && wr_lim_hi) begin
          par_lim[p][15:8] <= reg_wdata; // see R1 see R2 see R3
        end else if (wr_here && wr_lim_lo) begin
          par_lim[p][7:0] <= reg_wdata; // see R1 see R2 see R3
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data
  wire [7:0] sts_one = {1'b0, rp, crc_flag[rp], lock_change_flag[rp], seq_flag[rp],
                        par_flag[rp], pass_ok[rp], receiver_locked[rp]}; // see R5 see R10 see R11
  wire [7:0] sts_two = {2'b00, enc_flag[rp], 5'h00}; // see R12
  wire [7:0] sel_read = {phys_port, cur_sel[5:0]};
  wire [7:0] next_rdata =
      (reg_addr == rx_status_pkg::ADDR_PAGE_SEL) ? sel_read :
      (reg_addr == rx_status_pkg::ADDR_STS_ONE) ? sts_one :
      (reg_addr == rx_status_pkg::ADDR_STS_TWO) ? sts_two :
      (reg_addr == rx_status_pkg::ADDR_PAR_CNT_HI) ? par_cnt[rp][15:8] :
      (reg_addr == rx_status_pkg::ADDR_PAR_CNT_LO) ? par_cnt[rp][7:0] :
      (reg_addr == rx_status_pkg::ADDR_PAR_LIM_HI) ? par_lim[rp][15:8] :
      (reg_addr == rx_status_pkg::ADDR_PAR_LIM_LO) ? par_lim[rp][7:0] :
      rx_status_pkg::BYTE_ZERO;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= rx_status_pkg::BYTE_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_wr_block0;
    (wr_lim_lo || wr_lim_hi) && !wr_en[0] |=> $stable(par_lim[0]);
  endproperty
  a_wr_block0: assert property (p_wr_block0) // see R1
    else $error("port 0 limit changed while disabled");

  property p_wr_block1;
    (wr_lim_lo || wr_lim_hi) && !wr_en[1] |=> $stable(par_lim[1]);
  endproperty
  a_wr_block1: assert property (p_wr_block1) // see R2
    else $error("port 1 limit changed while disabled");

  property p_wr_both;
    wr_lim_lo && (wr_en == 2'b11) |=>
      (par_lim[0][7:0] == $past(reg_wdata)) && (par_lim[1][7:0] == $past(reg_wdata));
  endproperty
  a_wr_both: assert property (p_wr_both) // see R3
    else $error("broadcast write missed a port");

  property p_wr_pass0;
    wr_lim_lo && wr_en[0] |=> par_lim[0][7:0] == $past(reg_wdata);
  endproperty
  a_wr_pass0: assert property (p_wr_pass0) // see R1
    else $error("port 0 limit write lost while enabled");

  property p_wr_pass1;
    wr_lim_lo && wr_en[1] |=> par_lim[1][7:0] == $past(reg_wdata);
  endproperty
  a_wr_pass1: assert property (p_wr_pass1) // see R2
    else $error("port 1 limit write lost while enabled");

  property p_bcc_default;
    $rose(rstn) |-> (sel_reg[rx_status_pkg::SRC_BCC1] == rx_status_pkg::SEL_RST_BCC1);
  endproperty
  a_bcc_default: assert property (p_bcc_default) // see R4
    else $error("remote select default wrong");

  property p_local_default;
    $rose(rstn) |-> (sel_reg[rx_status_pkg::SRC_LOCAL] == rx_status_pkg::SEL_RST_LOCAL)
                 && (sel_reg[rx_status_pkg::SRC_BCC0] == rx_status_pkg::SEL_RST_BCC0);
  endproperty
  a_local_default: assert property (p_local_default) // see R4
    else $error("local or channel 0 select default wrong");

  property p_port_num;
    rd_sts1 |=> reg_rvalid && (reg_rdata[rx_status_pkg::STS1_PORT_BIT] == $past(rp));
  endproperty
  a_port_num: assert property (p_port_num) // see R5
    else $error("read port number wrong");

  property p_crc_clear;
    rd_sts1 && !rp && !crc_err_evt[0] |=> !crc_flag[0];
  endproperty
  a_crc_clear: assert property (p_crc_clear) // see R6
    else $error("crc flag not cleared by read");

  property p_seq_clear;
    rd_sts1 && !rp && !seq_err_evt[0] |=> !seq_flag[0];
  endproperty
  a_seq_clear: assert property (p_seq_clear) // see R7
    else $error("sequence flag not cleared by read");

  property p_seq_set;
    seq_err_evt[1] |=> seq_flag[1] [*1] ##0 (seq_flag[1] == 1'b1);
  endproperty
  a_seq_set: assert property (p_seq_set) // see R7
    else $error("sequence flag not latched");

  property p_par_set;
    over_lim[0] && !par_clr[0] |=> par_flag[0] ##1 (par_flag[0] || $past(par_clr[0]));
  endproperty
  a_par_set: assert property (p_par_set) // see R8
    else $error("parity flag not set above limit");

  property p_par_hold;
    par_flag[0] && !par_clr[0] |=> par_flag[0];
  endproperty
  a_par_hold: assert property (p_par_hold) // see R9
    else $error("parity flag dropped without count clear");

  property p_par_clear;
    par_clr[1] |=> !par_flag[1] && (par_cnt[1] <= rx_status_pkg::PAR_CNT_ONE);
  endproperty
  a_par_clear: assert property (p_par_clear) // see R9
    else $error("parity clear incomplete");

  property p_cnt_read_clear;
    rd_cnt_lo && !rp && !parity_err_evt[0]
      |=> (par_cnt[0] == rx_status_pkg::PAR_CNT_RST) && !par_flag[0];
  endproperty
  a_cnt_read_clear: assert property (p_cnt_read_clear) // see R14
    else $error("count low read did not clear count");

  property p_cnt_lock_clear;
    receiver_locked[0] && !lock_prev[0]
      |=> (par_cnt[0] <= rx_status_pkg::PAR_CNT_ONE) && !par_flag[0];
  endproperty
  a_cnt_lock_clear: assert property (p_cnt_lock_clear) // see R14
    else $error("lock rise did not clear count");

  property p_lock_read;
    rd_sts1 |=> reg_rdata[rx_status_pkg::STS1_LOCK_BIT] == $past(receiver_locked[rp])
            && reg_rdata[rx_status_pkg::STS1_PASS_BIT] == $past(pass_ok[rp]);
  endproperty
  a_lock_read: assert property (p_lock_read) // see R11
    else $error("live lock or pass bit wrong");

  property p_pass_read;
    rd_sts1 |=> reg_rdata[rx_status_pkg::STS1_PASS_BIT] == $past(pass_ok[rp]);
  endproperty
  a_pass_read: assert property (p_pass_read) // see R10
    else $error("pass bit not live");

  property p_rd_page;
    reg_rd && (reg_addr == rx_status_pkg::ADDR_PAR_LIM_LO)
      |=> reg_rdata == $past(par_lim[rp][7:0]);
  endproperty
  a_rd_page: assert property (p_rd_page) // see R13
    else $error("limit read from wrong port");

  property p_page_phys;
    reg_rd && reg_src_bcc && (reg_addr == rx_status_pkg::ADDR_PAGE_SEL)
      |=> reg_rdata[rx_status_pkg::SEL_PHYS_LSB +: 2] == $past({1'b0, reg_src_port});
  endproperty
  a_page_phys: assert property (p_page_phys) // see R13
    else $error("accessor port number wrong");

  property p_enc_keep;
    encode_err_evt[0] && rd_sts2 |=> enc_flag[0];
  endproperty
  a_enc_keep: assert property (p_enc_keep) // see R15
    else $error("encode error lost at clear");

  property p_crc_keep;
    crc_err_evt[0] && rd_sts1 |=> crc_flag[0];
  endproperty
  a_crc_keep: assert property (p_crc_keep) // see R15
    else $error("crc error lost at clear");

  property p_enc_clear;
    rd_sts2 && rp && !encode_err_evt[1]
      |=> !enc_flag[1] ##1 (enc_flag[1] == $past(encode_err_evt[1]));
  endproperty
  a_enc_clear: assert property (p_enc_clear) // see R12
    else $error("encode flag clear wrong");

  property p_enc_set;
    encode_err_evt[1] |=> enc_flag[1];
  endproperty
  a_enc_set: assert property (p_enc_set) // see R12
    else $error("encode flag not latched");

  c_broadcast: cover property (wr_lim_lo && wr_en == 2'b11);
  c_par_over: cover property (over_lim[1] ##1 par_flag[1] ##[1:20] par_clr[1]);
  c_crc_race: cover property (crc_err_evt[0] && rd_sts1 && !rp);
  c_enc_race: cover property (encode_err_evt[0] && rd_sts2 && !rp);
  c_remote_read: cover property (reg_rd && reg_src_bcc && reg_src_port);
endmodule

// [rx_status_pkg.sv]
// constants for the receive-port status and write-paging register bank
package rx_status_pkg;
  localparam int NUM_PORTS = 2;
  localparam int NUM_SRC = 3;
  // register offsets
  localparam logic [7:0] ADDR_PAGE_SEL = 8'h4c;
  localparam logic [7:0] ADDR_STS_ONE = 8'h4d;
  localparam logic [7:0] ADDR_STS_TWO = 8'h4e;
  localparam logic [7:0] ADDR_PAR_CNT_HI = 8'h55;
  localparam logic [7:0] ADDR_PAR_CNT_LO = 8'h56;
  localparam logic [7:0] ADDR_PAR_LIM_HI = 8'h57;
  localparam logic [7:0] ADDR_PAR_LIM_LO = 8'h58;
  // page-select fields
  localparam int SEL_WE0_BIT = 0;
  localparam int SEL_WE1_BIT = 1;
  localparam int SEL_RD_BIT = 4;
  localparam int SEL_PHYS_LSB = 6;
  localparam logic [7:0] SEL_WMASK = 8'h13;
  // access sources
  localparam logic [1:0] SRC_LOCAL = 2'h0;
  localparam logic [1:0] SRC_BCC0 = 2'h1;
  localparam logic [1:0] SRC_BCC1 = 2'h2;
  // page-select reset values per access source
  localparam logic [7:0] SEL_RST_LOCAL = 8'h00;
  localparam logic [7:0] SEL_RST_BCC0 = 8'h01;
  localparam logic [7:0] SEL_RST_BCC1 = 8'h12;
  // status one fields
  localparam int STS1_PORT_BIT = 6;
  localparam int STS1_CRC_BIT = 5;
  localparam int STS1_LCHG_BIT = 4;
  localparam int STS1_SEQ_BIT = 3;
  localparam int STS1_PAR_BIT = 2;
  localparam int STS1_PASS_BIT = 1;
  localparam int STS1_LOCK_BIT = 0;
  // status two fields
  localparam int STS2_ENC_BIT = 5;
  // parity counter and threshold
  localparam logic [15:0] PAR_CNT_RST = 16'h0000;
  localparam logic [15:0] PAR_CNT_ONE = 16'h0001;
  localparam logic [15:0] PAR_CNT_MAX = 16'hffff;
  localparam logic [15:0] PAR_LIM_RST = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// [rx_host_model.sv]
// host model issuing register cycles on the local bus or a control channel
`timescale 1ns/1ps
module rx_host_model (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_src_bcc,
  output logic reg_src_port,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_src_bcc = 1'b0;
    reg_src_port = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  // one write: strobe for one edge, address and data held with it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_src_bcc <= 1'b0;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one read from the chosen source, waits a bounded time for the answer
  task automatic rd(input logic bcc, input logic prt, input logic [7:0] a, output logic [7:0] d);
    int i;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    reg_src_bcc <= bcc;
    reg_src_port <= prt;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    d = reg_rdata;
  endtask
endmodule

// [tb_top.sv]
// self-checking bench for the receive-port status and paging registers
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr, reg_rd, reg_src_bcc, reg_src_port, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [1:0] crc = 2'h0, seq = 2'h0, par = 2'h0, enc = 2'h0, lck = 2'h0, pas = 2'h0;
  int failures = 0;
  int n_compared = 0;
  // rows: source channel, source port, address, expected data
  localparam logic [17:0] rows [8] = '{
    {1'b0, 1'b0, 8'h4c, 8'h00}, {1'b1, 1'b0, 8'h4c, 8'h01}, {1'b1, 1'b1, 8'h4c, 8'h52},
    {1'b0, 1'b0, 8'h57, 8'h00}, {1'b0, 1'b0, 8'h58, 8'h01}, {1'b0, 1'b0, 8'h40, 8'h00},
    {1'b0, 1'b0, 8'h4e, 8'h00}, {1'b0, 1'b0, 8'h4d, 8'h00}};
  initial forever #20 clk_sys = ~clk_sys;
  rx_port_status_regs rx_port_status_regs_i (.clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_src_bcc(reg_src_bcc),
    .reg_src_port(reg_src_port), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .crc_err_evt(crc), .seq_err_evt(seq), .parity_err_evt(par), .encode_err_evt(enc),
    .receiver_locked(lck), .pass_ok(pas));
  rx_host_model rx_host_model_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_src_bcc(reg_src_bcc),
    .reg_src_port(reg_src_port), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic lrd(input logic [7:0] a, input logic [7:0] exp);
    rx_host_model_i.rd(1'b0, 1'b0, a, d);
    check(d, exp);
  endtask
  // one-cycle event pulse on the chosen ports
  task automatic pev(input logic [1:0] c, input logic [1:0] s, input logic [1:0] p,
                     input logic [1:0] e);
    @(posedge clk_sys);
    {crc, seq, par, enc} <= {c, s, p, e};
    @(posedge clk_sys);
    {crc, seq, par, enc} <= 8'h00;
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      rx_host_model_i.rd(rows[i][17], rows[i][16], rows[i][15:8], d);
      check(d, rows[i][7:0]);
    end
    rx_host_model_i.wr(8'h58, 8'h05);
    lrd(8'h58, 8'h01);
    rx_host_model_i.wr(8'h4c, 8'h01);
    rx_host_model_i.wr(8'h58, 8'h05);
    lrd(8'h58, 8'h05);
    rx_host_model_i.wr(8'h4c, 8'h10);
    lrd(8'h58, 8'h01);
    lrd(8'h4d, 8'h40);
    rx_host_model_i.wr(8'h58, 8'h09);
    lrd(8'h58, 8'h01);
    rx_host_model_i.wr(8'h4c, 8'h03);
    rx_host_model_i.wr(8'h58, 8'h02);
    lrd(8'h58, 8'h02);
    rx_host_model_i.wr(8'h4c, 8'h13);
    lrd(8'h58, 8'h02);
    rx_host_model_i.wr(8'h4c, 8'h00);
    pev(2'h0, 2'h0, 2'h1, 2'h0);
    pev(2'h0, 2'h0, 2'h1, 2'h0);
    lrd(8'h4d, 8'h00);
    pev(2'h0, 2'h0, 2'h1, 2'h0);
    lrd(8'h4d, 8'h04);
    lrd(8'h4d, 8'h04);
    lrd(8'h55, 8'h00);
    lrd(8'h56, 8'h03);
    lrd(8'h4d, 8'h00);
    pev(2'h1, 2'h1, 2'h0, 2'h1);
    lrd(8'h4d, 8'h28);
    lrd(8'h4d, 8'h00);
    lrd(8'h4e, 8'h20);
    lrd(8'h4e, 8'h00);
    fork
      rx_host_model_i.rd(1'b0, 1'b0, 8'h4d, d);
      pev(2'h1, 2'h0, 2'h0, 2'h0);
    join
    check(d, 8'h00);
    lrd(8'h4d, 8'h20);
    pev(2'h0, 2'h0, 2'h1, 2'h0);
    @(posedge clk_sys);
    {lck, pas} <= 4'h5;
    repeat (2) @(posedge clk_sys);
    lrd(8'h56, 8'h00);
    lrd(8'h4d, 8'h13);
    lrd(8'h4d, 8'h03);
    @(posedge clk_sys);
    pas <= 2'h0;
    lrd(8'h4d, 8'h01);
    rx_host_model_i.wr(8'h4c, 8'h10);
    pev(2'h0, 2'h2, 2'h2, 2'h2);
    lrd(8'h4d, 8'h48);
    lrd(8'h4e, 8'h20);
    lrd(8'h4e, 8'h00);
    lrd(8'h56, 8'h01);
    lrd(8'h56, 8'h00);
    rx_host_model_i.wr(8'h4c, 8'h00);
    fork
      rx_host_model_i.rd(1'b0, 1'b0, 8'h4e, d);
      pev(2'h0, 2'h0, 2'h0, 2'h1);
    join
    check(d, 8'h00);
    lrd(8'h4e, 8'h20);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h00, reg_rvalid}, 8'h00);
    check(reg_rdata, 8'h00);
    @(posedge clk_sys);
    rstn <= 1'b1;
    lrd(8'h58, 8'h01);
    end_of_test();
  end
endmodule
